// >>> src/gtm_top.v
// general timer module: five timers, toggle latch and axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "gtm_defines.vh"

module gtm_top #(
	parameter W = 16,
	parameter PW = 10,
	parameter AW = 8
) (
	input wire core_clk,
	input wire rst_b,
	input wire clkEn,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	output wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	input wire [AW-1:0] s_axi_araddr,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	input wire [4:0] tinPinA,
	input wire [4:0] tinPinB,
	input wire [4:0] eudPinA,
	input wire [4:0] eudPinB,
	output wire toggleOutPin,
	output wire irqNodeZero,
	output wire irqNodeOne
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg [`GTM_CTL_W-1:0] ctl_q [0:4];
reg [W-1:0] capture_reload_register_q;
reg [`GTM_INPUT_SOURCE_SELECT_W-1:0] input_source_select_q;
reg [PW-1:0] pre_q;
reg otl_q;
reg shadow_q;
reg toggleOut_q;
reg irq0_q;
reg irq1_q;
reg awRdy_q, wRdy_q, awHave_q, wHave_q, bVal_q, arRdy_q, rVal_q;
reg [AW-1:0] awAddr_q;
reg [31:0] wData_q;
reg [3:0] wStrb_q;
reg [1:0] bResp_q;
reg [31:0] rData_q;
reg [1:0] rResp_q;
wire [W-1:0] cnt [0:4];
wire [4:0] ovf;
wire [4:0] tinEdge;
wire [4:0] cntWr;

assign s_axi_awready = awRdy_q;
assign s_axi_wready = wRdy_q;
assign s_axi_bvalid = bVal_q;
assign s_axi_bresp = bResp_q;
assign s_axi_arready = arRdy_q;
assign s_axi_rvalid = rVal_q;
assign s_axi_rdata = rData_q;
assign s_axi_rresp = rResp_q;
assign toggleOutPin = toggleOut_q;
assign irqNodeZero = irq0_q;
assign irqNodeOne = irq1_q;

function [31:0] merge;
	input [31:0] oldV;
	input [31:0] newV;
	input [3:0] strb;
	integer b;
	begin
		for (b = 0; b < 4; b = b + 1) begin
			merge[8*b +: 8] = strb[b] ? newV[8*b +: 8] : oldV[8*b +: 8];
		end
	end
endfunction

// ------------------------------------------------------------
// write decode
// ------------------------------------------------------------
wire [5:0] wIdx = awAddr_q[7:2];
wire doWrite = awHave_q & wHave_q & ~bVal_q;
wire wInRange = wIdx[2:0] < `GTM_NUM_TMR;
wire wCtl = (wIdx[5:3] == `GTM_BLK_CTL) & wInRange;
wire wCnt = (wIdx[5:3] == `GTM_BLK_CNT) & wInRange;
wire wCap = wIdx == `GTM_IDX_CAPTURE_RELOAD_REGISTER;
wire wPis = wIdx == `GTM_IDX_INPUT_SOURCE_SELECT;
wire wHit = wCtl | wCnt | wCap | wPis;
wire [31:0] cntMerged = merge({{(32-W){1'b0}}, cnt[wIdx[2:0]]},
	wData_q, wStrb_q);
wire [31:0] ctlMerged = merge({{(32-`GTM_CTL_W){1'b0}},
	ctl_q[wIdx[2:0]]}, wData_q, wStrb_q);
wire [31:0] capMerged = merge({{(32-W){1'b0}}, capture_reload_register_q},
	wData_q, wStrb_q);

// ------------------------------------------------------------
// toggle latch, reload and capture plumbing
// ------------------------------------------------------------
wire [2:0] modeA = ctl_q[`GTM_T_AUXA][`GTM_F_MODE];
wire [2:0] modeB = ctl_q[`GTM_T_AUXB][`GTM_F_MODE];
wire [2:0] mode2 = ctl_q[`GTM_T_AUX2][`GTM_F_MODE];
// latch and its one-cycle shadow differ only after a hardware toggle
wire otlEdge = otl_q ^ shadow_q; // [R10]
wire relA = (modeA == `GTM_MODE_RELOAD) & ovf[`GTM_T_CORE1];
wire relB = (modeB == `GTM_MODE_RELOAD) & ovf[`GTM_T_CORE1];
wire rel2 = (mode2 == `GTM_MODE_RELOAD) & ovf[`GTM_T_CORE2]; // [R04]
wire cap2 = (mode2 == `GTM_MODE_CAPTURE) & tinEdge[`GTM_T_AUX2]; // [R04]
wire otlSwWr = doWrite & wCtl & (wIdx[2:0] == `GTM_T_CORE1) & wStrb_q[1];

// ------------------------------------------------------------
// timers
// ------------------------------------------------------------
genvar g;
generate
	for (g = 0; g < 5; g = g + 1) begin : gTmr // [R01]
		localparam [2:0] GI = g;
		wire [`GTM_CTL_W-1:0] c = ctl_q[g];
		wire tinSel = input_source_select_q[g] ? tinPinB[g] : tinPinA[g]; // [R16]
		wire eudSel = input_source_select_q[g+5] ? eudPinB[g] : eudPinA[g]; // [R16]
		wire chainIn;
		wire ldEn;
		wire [W-1:0] ldData;
		if (g == `GTM_T_CORE1) begin : gCore1
			assign chainIn = 1'b0;
			assign ldEn = relA | relB; // [R10]
			assign ldData = relA ? cnt[`GTM_T_AUXA] : cnt[`GTM_T_AUXB];
		end else if (g == `GTM_T_CORE2) begin : gCore2
			assign chainIn = 1'b0;
			assign ldEn = rel2;
			assign ldData = capture_reload_register_q;
		end else if (g == `GTM_T_AUX2) begin : gAux2
			assign chainIn = ovf[`GTM_T_CORE2]; // [R11]
			assign ldEn = 1'b0;
			assign ldData = {W{1'b0}};
		end else begin : gAux1
			assign chainIn = otlEdge; // [R10] [R11]
			assign ldEn = (c[`GTM_F_MODE] == `GTM_MODE_CAPTURE) & tinEdge[g];
			assign ldData = cnt[`GTM_T_CORE1];
		end
		assign cntWr[g] = doWrite & wCnt & (wIdx[2:0] == GI); // [R12] [R13]
		gtm_timer #(
			.W(W),
			.PW(PW),
			.BASE(g < 3 ? `GTM_G1_SHIFT : `GTM_G2_SHIFT) // [R02] [R03]
		) uTmr (
			.core_clk(core_clk),
			.rst_b(rst_b),
			.clkEn(clkEn),
			.preCnt(pre_q),
			.mode(c[`GTM_F_MODE]), // [R06]
			.sel(c[`GTM_F_SEL]),
			.run(c[`GTM_F_RUN]), // [R18]
			.ud(c[`GTM_F_UD]),
			.ude(c[`GTM_F_UDE]),
			.tinPin(tinSel),
			.eudPin(eudSel),
			.chainEvt(chainIn),
			.wrEn(cntWr[g]),
			.wrData(cntMerged[W-1:0]),
			.loadEn(ldEn),
			.loadData(ldData),
			.count(cnt[g]),
			.ovfPulse(ovf[g]),
			.tinEdge(tinEdge[g])
		);
	end
endgenerate

// ------------------------------------------------------------
// read mux
// ------------------------------------------------------------
wire [5:0] rIdx = s_axi_araddr[7:2];
wire rInRange = rIdx[2:0] < `GTM_NUM_TMR;
reg [31:0] rdWord;
reg rdHit;
always @* begin
	rdWord = 32'h0000_0000;
	rdHit = 1'b1;
	if ((rIdx[5:3] == `GTM_BLK_CTL) && rInRange) begin
		rdWord[`GTM_CTL_W-1:0] = ctl_q[rIdx[2:0]];
		if (rIdx[2:0] == `GTM_T_CORE1) begin
			rdWord[`GTM_F_OTL] = otl_q;
		end
	end else if ((rIdx[5:3] == `GTM_BLK_CNT) && rInRange) begin
		rdWord[W-1:0] = cnt[rIdx[2:0]]; // [R12]
	end else if (rIdx == `GTM_IDX_CAPTURE_RELOAD_REGISTER) begin
		rdWord[W-1:0] = capture_reload_register_q;
	end else if (rIdx == `GTM_IDX_INPUT_SOURCE_SELECT) begin
		rdWord[`GTM_INPUT_SOURCE_SELECT_W-1:0] = input_source_select_q;
	end else begin
		rdHit = 1'b0;
	end
end

// ------------------------------------------------------------
// registers, latch and interrupt node pulses
// ------------------------------------------------------------
integer i;
always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		for (i = 0; i < 5; i = i + 1) begin
			ctl_q[i] <= `GTM_CTL_RST;
		end
		capture_reload_register_q <= {W{1'b0}};
		input_source_select_q <= {`GTM_INPUT_SOURCE_SELECT_W{1'b0}};
		pre_q <= {PW{1'b0}};
		otl_q <= 1'b0;
		shadow_q <= 1'b0;
		toggleOut_q <= 1'b1;
		irq0_q <= 1'b0;
		irq1_q <= 1'b0;
	end else if (clkEn) begin // [R17]
		pre_q <= pre_q + 1'b1;
		if (doWrite && wCtl) begin
			ctl_q[wIdx[2:0]] <= ctlMerged[`GTM_CTL_W-1:0];
		end
		if (doWrite && wPis) begin
			input_source_select_q <= wData_q[`GTM_INPUT_SOURCE_SELECT_W-1:0] & ~{`GTM_INPUT_SOURCE_SELECT_W{1'b0}};
		end
		if (doWrite && wCap) begin
			capture_reload_register_q <= capMerged[W-1:0]; // [R13]
		end else if (cap2) begin
			capture_reload_register_q <= cnt[`GTM_T_CORE2]; // [R04]
		end
		// software write moves both latches so no chain edge appears
		if (otlSwWr) begin
			otl_q <= wData_q[`GTM_F_OTL];
			shadow_q <= wData_q[`GTM_F_OTL];
		end else begin
			if (ovf[`GTM_T_CORE1]) begin
				otl_q <= ~otl_q; // [R09]
			end
			shadow_q <= otl_q;
		end
		toggleOut_q <= ctl_q[`GTM_T_CORE1][`GTM_F_OE] ? otl_q : 1'b1; // [R09]
		// only request pulses leave; enable and pending bits sit outside
		irq0_q <= |ovf[2:0] | (|(tinEdge[2:0] & {
			modeB == `GTM_MODE_CAPTURE, 1'b0,
			modeA == `GTM_MODE_CAPTURE})); // [R14] [R15]
		irq1_q <= |ovf[4:3] | cap2; // [R14]
	end
end

// ------------------------------------------------------------
// axi4-lite handshakes
// ------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		awRdy_q <= 1'b0;
		wRdy_q <= 1'b0;
		awHave_q <= 1'b0;
		wHave_q <= 1'b0;
		bVal_q <= 1'b0;
		bResp_q <= `GTM_RESP_OKAY;
		arRdy_q <= 1'b0;
		rVal_q <= 1'b0;
		awAddr_q <= {AW{1'b0}};
		wData_q <= 32'h0000_0000;
		wStrb_q <= 4'h0;
		rData_q <= 32'h0000_0000;
		rResp_q <= `GTM_RESP_OKAY;
	end else if (clkEn) begin
		// ready is a one-cycle offer so a held valid is taken once
		awRdy_q <= ~awRdy_q & s_axi_awvalid & ~awHave_q & ~bVal_q;
		wRdy_q <= ~wRdy_q & s_axi_wvalid & ~wHave_q & ~bVal_q;
		if (awRdy_q && s_axi_awvalid) begin
			awHave_q <= 1'b1;
			awAddr_q <= s_axi_awaddr;
		end
		if (wRdy_q && s_axi_wvalid) begin
			wHave_q <= 1'b1;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end
		if (doWrite) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			bVal_q <= 1'b1;
			bResp_q <= wHit ? `GTM_RESP_OKAY : `GTM_RESP_SLVERR;
		end else if (bVal_q && s_axi_bready) begin
			bVal_q <= 1'b0;
		end
		arRdy_q <= ~arRdy_q & s_axi_arvalid & ~rVal_q;
		if (arRdy_q && s_axi_arvalid) begin
			rVal_q <= 1'b1;
			rData_q <= rdWord;
			rResp_q <= rdHit ? `GTM_RESP_OKAY : `GTM_RESP_SLVERR;
		end else if (rVal_q && s_axi_rready) begin
			rVal_q <= 1'b0;
		end
	end
end

endmodule // gtm_top
`default_nettype wire

// >>> src/gtm_defines.vh
// constants for the general timer module: fields, modes, register map
// Notes on behaviour
// [R01] five 16-bit timers in two groups, three in group one, two in group two
// [R02] group one: core plus two aux timers, finest step module clock over four
// [R03] group two: core plus one aux timer, finest step module clock over two
// [R04] group two owns an extra 16-bit capture/reload register
// [R05] group one timers run timer, gated, counter or incremental encoder mode
// [R06] every group one timer has its own control register
// [R07] count up or down, from software bit or external direction pin
// [R08] input pin gates in gated mode and gives events in counter mode
// [R09] group one core over/underflow toggles a latch, drivable onto a pin
// [R10] group one aux timers chain through the latch or capture/reload core
// [R11] timers run alone or chained to a timer of the same group
// [R12] cpu reads and writes every count register
// [R13] cpu write to a count beats a same-cycle count, reload or capture
// [R14] group one events share node zero, group two events share node one
// [R15] interrupt enable and request registers live outside this block
// [R16] timer inputs picked from alternative sources by a select register
// [R17] whole module runs on one module clock taken from the system clock
// [R18] group one core runs while run bit set; gated mode also needs gate
// [R19] mode 000 timer, 001 counter, 01x gated, 11x incremental interface
// [R20] counts wrap all ones to zero up, zero to all ones down, flagging it
`ifndef GTM_DEFINES_VH
`define GTM_DEFINES_VH

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define GTM_CTL_W 11
`define GTM_F_MODE 2:0
`define GTM_F_SEL 5:3
`define GTM_F_RUN 6
`define GTM_F_UD 7
`define GTM_F_UDE 8
`define GTM_F_OTL 9
`define GTM_F_OE 10
`define GTM_CTL_RST 11'h000

// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define GTM_MODE_TIMER 3'h0
`define GTM_MODE_COUNTER 3'h1
`define GTM_MODE_GATED_LO 3'h2
`define GTM_MODE_GATED_HI 3'h3
`define GTM_MODE_CAPTURE 3'h4
`define GTM_MODE_RELOAD 3'h5
`define GTM_MODE_INCR_ROT 3'h6
`define GTM_MODE_INCR_EDGE 3'h7

// ------------------------------------------------------------
// prescale base shifts and timer indices
// ------------------------------------------------------------
`define GTM_G1_SHIFT 2
`define GTM_G2_SHIFT 1
`define GTM_T_AUXA 1'b0
`define GTM_T_CORE1 1
`define GTM_T_AUXB 2
`define GTM_T_AUX2 3
`define GTM_T_CORE2 4

// ------------------------------------------------------------
// register map, word indices (byte address = index * 4)
// ------------------------------------------------------------
`define GTM_BLK_CTL 3'h0
`define GTM_BLK_CNT 3'h1
`define GTM_NUM_TMR 3'h5
`define GTM_IDX_CAPTURE_RELOAD_REGISTER 6'h10
`define GTM_IDX_INPUT_SOURCE_SELECT 6'h11
`define GTM_INPUT_SOURCE_SELECT_W 10
`define GTM_RESP_OKAY 2'h0
`define GTM_RESP_SLVERR 2'h2

`endif

// >>> src/gtm_timer.v
// one 16-bit timer/counter with mode, direction and load handling
`timescale 1ns/10ps
`default_nettype none
`include "gtm_defines.vh"

module gtm_timer #(
	parameter W = 16,
	parameter PW = 10,
	parameter BASE = 2
) (
	input wire core_clk,
	input wire rst_b,
	input wire clkEn,
	input wire [PW-1:0] preCnt,
	input wire [2:0] mode,
	input wire [2:0] sel,
	input wire run,
	input wire ud,
	input wire ude,
	input wire tinPin,
	input wire eudPin,
	input wire chainEvt,
	input wire wrEn,
	input wire [W-1:0] wrData,
	input wire loadEn,
	input wire [W-1:0] loadData,
	output wire [W-1:0] count,
	output wire ovfPulse,
	output wire tinEdge
);

reg [W-1:0] cnt_q;
reg [W-1:0] cnt_d;
reg tinPrev_q;
reg eudPrev_q;
reg step;
reg down;
wire tinRise = tinPin & ~tinPrev_q;
wire tinFall = ~tinPin & tinPrev_q;
wire tinChg = tinPin ^ tinPrev_q;
wire eudChg = eudPin ^ eudPrev_q;
wire [PW-1:0] preMask = ~({PW{1'b1}} << (BASE + sel));
// finest step is the base division; sel adds powers of two
wire tick = &(preCnt | ~preMask); // [R02] [R03]
wire selEdge = (sel[0] & tinRise) | (sel[1] & tinFall);
wire swDown = ude ? (eudPin ^ ud) : ud; // [R07]
wire atEnd = down ? (cnt_q == {W{1'b0}}) : (cnt_q == {W{1'b1}});

assign count = cnt_q;
assign tinEdge = selEdge;
// a reload is triggered by this pulse, so it must not gate it (no loop)
assign ovfPulse = step & ~wrEn & atEnd; // [R20]

// ------------------------------------------------------------
// step and direction
// ------------------------------------------------------------
always @* begin
	step = 1'b0;
	down = swDown;
	case (mode)
	`GTM_MODE_TIMER: step = run & tick; // [R19]
	`GTM_MODE_COUNTER: step = run & (sel[2] ? chainEvt : selEdge); // [R08] [R11]
	`GTM_MODE_GATED_LO, `GTM_MODE_GATED_HI:
		step = run & tick & (tinPin == mode[0]); // [R08] [R18]
	`GTM_MODE_INCR_ROT, `GTM_MODE_INCR_EDGE: begin
		// quadrature: phase order gives direction
		step = run & (tinChg | (sel[1] & eudChg)); // [R05]
		down = (tinChg ? (tinPin == eudPin) : (tinPin != eudPin)) ^ ud;
	end
	default: step = 1'b0;
	endcase
end

always @* begin
	if (wrEn) begin
		cnt_d = wrData; // [R13]
	end else if (loadEn) begin
		cnt_d = loadData;
	end else if (step) begin
		cnt_d = down ? cnt_q - 1'b1 : cnt_q + 1'b1; // [R20]
	end else begin
		cnt_d = cnt_q;
	end
end

always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		cnt_q <= {W{1'b0}};
		tinPrev_q <= 1'b0;
		eudPrev_q <= 1'b0;
	end else if (clkEn) begin
		cnt_q <= cnt_d;
		tinPrev_q <= tinPin;
		eudPrev_q <= eudPin;
	end
end

endmodule // gtm_timer
`default_nettype wire

// >>> tb/gtm_top_assertions.sv
// concurrent checks on the bus and pin ports of the general timer module
`timescale 1ns/10ps
`default_nettype none
module gtm_top_assertions (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic toggleOutPin
);
	// ------------------------------------------------
	// clocking and handshake steps
	// ------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence sWrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sRdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_WR_ANSWER: assert property (sWrTaken |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (sRdTaken |=> s_axi_rvalid)
		else $error("read not answered");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready held");
	AST_SLVERR_ZERO: assert property (
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
	// a frozen clock enable must hold the toggle pin and both response valids
	AST_FREEZE: assert property (
		!clkEn |=> $stable({toggleOutPin, s_axi_bvalid, s_axi_rvalid}))
		else $error("state moved while frozen");
	AST_B_CAUSE: assert property (
		$rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready, 2))
		else $error("write response without a write");
endmodule // gtm_top_assertions

bind gtm_top gtm_top_assertions chk_u (
	.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .toggleOutPin(toggleOutPin)
);
`default_nettype wire

// >>> tb/gtm_pin_model.sv
// external pin model: count pulses, gate and direction levels
`timescale 1ns/10ps
`default_nettype none
module gtm_pin_model (
	input wire logic core_clk,
	output logic [4:0] tinPinA,
	output logic [4:0] tinPinB,
	output logic [4:0] eudPinA,
	output logic [4:0] eudPinB
);
	initial begin
		tinPinA = 5'h00;
		tinPinB = 5'h00;
		eudPinA = 5'h1F;
		eudPinB = 5'h00;
	end
	// each level is held four clocks so the pin sampler sees every edge
	task pulses(input logic useB, input int idx, input int n);
		repeat (2 * n) begin
			@(posedge core_clk);
			if (useB) tinPinB[idx] <= ~tinPinB[idx];
			else tinPinA[idx] <= ~tinPinA[idx];
			repeat (3) @(posedge core_clk);
		end
	endtask
	task level(input int idx, input logic v);
		@(posedge core_clk);
		tinPinA[idx] <= v;
	endtask
endmodule // gtm_pin_model
`default_nettype wire

// >>> tb/general_purpose_timer_blocks_tb.sv
// self-checking bench of the general timer module over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "gtm_defines.vh"
module general_purpose_timer_blocks_tb;
	// ------------------------------------------------
	// stimulus, wiring and the design
	// ------------------------------------------------
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clkEn = 1'b1;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] lastResp;
	logic [31:0] d;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic s_axi_rvalid, toggleOutPin, irqNodeZero, irqNodeOne;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [4:0] tinPinA, tinPinB, eudPinA, eudPinB;
	int bad_count = 0;
	int checks = 0;
	int irq0Cnt = 0;
	int irq1Cnt = 0;
	int i, j0, j1;
	int cIdx[5] = '{1, 1, 1, 4, 0};
	logic [31:0] cCtl[5] = '{32'h449, 32'h4C9, 32'h549, 32'h049, 32'h049};
	logic [31:0] cEnd[5] = '{32'h649, 32'h6C9, 32'h749, 32'h049, 32'h049};
	logic [31:0] cFrom[5] = '{32'hFFFE, 32'h1, 32'h1, 32'hFFFE, 32'h1234};
	logic [31:0] cTo[5] = '{32'h1, 32'hFFFE, 32'hFFFE, 32'h1, 32'h1237};
	int tIdx[2] = '{1, 4};
	int tLo[2] = '{95, 195};
	int tHi[2] = '{110, 215};

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (irqNodeZero === 1'b1) irq0Cnt++;
		if (irqNodeOne === 1'b1) irq1Cnt++;
	end

	gtm_top #(.W(16), .PW(10), .AW(8)) dut_u (.core_clk, .rst_b, .clkEn,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .tinPinA, .tinPinB, .eudPinA, .eudPinB,
		.toggleOutPin, .irqNodeZero, .irqNodeOne);
	gtm_pin_model pins_u (.core_clk, .tinPinA, .tinPinB, .eudPinA, .eudPinB);

	// ------------------------------------------------
	// bus tasks and comparison
	// ------------------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 64);
		lastResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (s_axi_bvalid !== 1'b1) begin
			bad_count++;
			tally_and_finish;
		end
		@(posedge core_clk);
	endtask
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 64);
		d = s_axi_rdata;
		lastResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (s_axi_rvalid !== 1'b1) begin
			bad_count++;
			tally_and_finish;
		end
		@(posedge core_clk);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		chk({31'h0, toggleOutPin}, 32'h1);
		for (i = 0; i < 5; i++) begin
			rchk(8'(4 * i), 32'h0);
			rchk(8'h20 + 8'(4 * i), 32'h0);
		end
		clkEn <= 1'b0;
		repeat (10) @(posedge core_clk);
		clkEn <= 1'b1;
		@(posedge core_clk);
		for (i = 0; i < 6; i++) begin
			d = (i == 5) ? 32'h40 : 32'h20 + 32'(4 * i);
			wr(d[7:0], 32'hA5C0 + 32'(i));
			rchk(8'(32'h20 + 4 * i + ((i == 5) ? 12 : 0)), 32'hA5C0 + 32'(i));
		end
		for (i = 0; i < 8; i++) begin
			wr(8'h08, 32'(i));
			rchk(8'h08, 32'(i));
		end
		wr(8'h08, 32'h0);
		wr(8'h80, 32'h1234);
		chk({30'h0, lastResp}, {30'h0, `GTM_RESP_SLVERR});
		rchk(8'h80, 32'h0);
		chk({30'h0, lastResp}, {30'h0, `GTM_RESP_SLVERR});
		for (i = 0; i < 5; i++) begin
			j0 = irq0Cnt;
			j1 = irq1Cnt;
			wr(8'h20 + 8'(4 * cIdx[i]), cFrom[i]);
			wr(8'(4 * cIdx[i]), cCtl[i]);
			chk({31'h0, toggleOutPin}, 32'(cIdx[i] != 1));
			pins_u.pulses(1'b0, cIdx[i], 3);
			repeat (4) @(posedge core_clk);
			chk({31'h0, toggleOutPin}, 32'h1);
			rchk(8'h20 + 8'(4 * cIdx[i]), cTo[i]);
			rchk(8'(4 * cIdx[i]), cEnd[i]);
			chk(32'(irq0Cnt - j0), 32'(cIdx[i] == 1));
			chk(32'(irq1Cnt - j1), 32'(cIdx[i] == 4));
			wr(8'(4 * cIdx[i]), 32'h0);
		end
		wr(8'h44, 32'h2);
		wr(8'h24, 32'h0);
		wr(8'h04, 32'h049);
		pins_u.pulses(1'b0, 1, 2);
		pins_u.pulses(1'b1, 1, 3);
		repeat (4) @(posedge core_clk);
		rchk(8'h24, 32'h3);
		wr(8'h44, 32'h0);
		wr(8'h24, 32'h0);
		wr(8'h04, 32'h043);
		repeat (40) @(posedge core_clk);
		rchk(8'h24, 32'h0);
		pins_u.level(1, 1'b1);
		repeat (40) @(posedge core_clk);
		wr(8'h04, 32'h0);
		rd(8'h24);
		chk(32'(d >= 8 && d <= 14), 32'h1);
		pins_u.level(1, 1'b0);
		// chain from the latch, reload from aux b, capture into capture_reload_register
		wr(8'h20, 32'h0);
		wr(8'h28, 32'h1230);
		wr(8'h24, 32'hFFFF);
		wr(8'h08, 32'h005);
		wr(8'h00, 32'h061);
		wr(8'h04, 32'h049);
		j0 = irq0Cnt;
		pins_u.pulses(1'b0, 1, 2);
		repeat (4) @(posedge core_clk);
		rchk(8'h24, 32'h1231);
		rchk(8'h20, 32'h1);
		chk(32'(irq0Cnt - j0), 32'h1);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h30, 32'h4321);
		wr(8'h0C, 32'h00C);
		j1 = irq1Cnt;
		pins_u.pulses(1'b0, 3, 1);
		repeat (4) @(posedge core_clk);
		rchk(8'h40, 32'h4321);
		chk(32'(irq1Cnt - j1), 32'h1);
		wr(8'h0C, 32'h0);
		// whole-run window hides prescaler phase, so a band is accepted
		for (i = 0; i < 2; i++) begin
			wr(8'h20 + 8'(4 * tIdx[i]), 32'h0);
			wr(8'(4 * tIdx[i]), 32'h040);
			repeat (400) @(posedge core_clk);
			wr(8'(4 * tIdx[i]), 32'h0);
			rd(8'h20 + 8'(4 * tIdx[i]));
			chk(32'(d >= tLo[i] && d <= tHi[i]), 32'h1);
		end
		tally_and_finish;
	end
endmodule // general_purpose_timer_blocks_tb
`default_nettype wire
